// *** src/param_bank_cfg.svh ***
// offsets, field positions, write masks and reset values of the bank
`ifndef PARAM_BANK_CFG_SVH
`define PARAM_BANK_CFG_SVH
`define PB_OFS_BUS_ADDR   5'h00
`define PB_OFS_CHAN_LIST  5'h01
`define PB_OFS_LED12      5'h02
`define PB_OFS_LED3       5'h03
`define PB_OFS_PROX_ALIGN 5'h05
`define PB_OFS_AMB_ALIGN  5'h06
`define PB_OFS_HISTORY    5'h19
`define PB_OFS_OFFSET     5'h1A
`define PB_OFS_RSVD_1B    5'h1B
`define PB_OFS_REC_TIME   5'h1C
`define PB_OFS_IR_COUNT   5'h1D
`define PB_OFS_IR_GAIN    5'h1E
`define PB_OFS_SELECT_A   5'h1F
`define PB_MASK_CHAN_LIST 8'h77
`define PB_MASK_LED12     8'h77
`define PB_MASK_LED3      8'h07
`define PB_MASK_PROX_AL   8'h70
`define PB_MASK_AMB_AL    8'h30
`define PB_MASK_IR_COUNT  8'h70
`define PB_MASK_IR_GAIN   8'h07
`define PB_MASK_SELECT_A  8'h20
`define PB_RST_ZERO       8'h00
`define PB_RST_LED12      8'h21
`define PB_RST_LED3       8'h04
`define PB_BIT_PROX_ONE   0
`define PB_BIT_PROX_TWO   1
`define PB_BIT_PROX_THREE 2
`define PB_BIT_AMB_VIS    4
`define PB_BIT_AMB_IR     5
`define PB_BIT_AUX        6
`define PB_BIT_PROX_ONE_AL   4
`define PB_BIT_PROX_TWO_AL   5
`define PB_BIT_PROX_THREE_AL 6
`define PB_BIT_AMB_B4_AL     4
`define PB_BIT_AMB_B5_AL     5
`endif

// *** src/param_bank_pkg.sv ***
// types shared by the parameter bank
package param_bank_pkg;
    // measurement that produced a conversion
    typedef enum logic [2:0] {
        SRC_PROX_ONE   = 3'h0,
        SRC_PROX_TWO   = 3'h1,
        SRC_PROX_THREE = 3'h2,
        SRC_AMB_VIS    = 3'h3,
        SRC_AMB_IR     = 3'h4,
        SRC_AUX        = 3'h5
    } conv_source_t;

    // whole state of the bank
    typedef struct packed {
        logic [7:0]   bus_address_param;
        logic [7:0]   active_bus_address;
        logic [7:0]   channel_enable_list;
        logic [7:0]   prox_led_select_one_two;
        logic [7:0]   prox_led_select_three;
        logic [7:0]   prox_result_alignment;
        logic [7:0]   ambient_result_alignment;
        logic [7:0]   ambient_history_setting;
        logic [7:0]   converter_offset_setting;
        logic [7:0]   emitter_recovery_time;
        logic [7:0]   ambient_ir_recovery_count;
        logic [7:0]   ambient_ir_gain;
        logic [7:0]   ambient_select_a_ctl;
        logic [7:0]   rdata;
        logic         rdata_valid;
        logic [15:0]  result_data;
        logic         result_valid;
        conv_source_t result_source;
    } bank_state_t;
endpackage

// *** src/sensor_channel_parameter_bank.sv ***
// indirectly addressed parameter bank with result alignment
`include "param_bank_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sensor_channel_parameter_bank #(
    parameter logic [7:0] RESET_BUS_ADDRESS = 8'h00  // plain default
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // parameter command port from the command engine
    input  wire logic        parameter_write_cmd,
    input  wire logic        parameter_read_cmd,
    input  wire logic [4:0]  param_offset,
    input  wire logic [7:0]  param_wdata,
    output logic      [7:0]  param_rdata,
    output logic             param_rdata_valid,
    input  wire logic        apply_bus_address_cmd,
    output logic      [7:0]  active_bus_address,
    // channel enables
    output logic             prox_one_on,
    output logic             prox_two_on,
    output logic             prox_three_on,
    output logic             ambient_visible_channel_on,
    output logic             ambient_ir_channel_on,
    output logic             aux_channel_on,
    // emitter driver selections
    output logic      [2:0]  prox_one_driver_mask,
    output logic      [2:0]  prox_two_driver_mask,
    output logic      [2:0]  prox_three_driver_mask,
    // alignment flags
    output logic             prox_one_low_bits,
    output logic             prox_two_low_bits,
    output logic             prox_three_low_bits,
    output logic             ambient_bit5_low_bits,
    output logic             ambient_bit4_low_bits,
    // raw conversion in, aligned result out
    input  wire logic        conv_valid,
    input  wire logic [2:0]  conv_source,
    input  wire logic [16:0] conv_data,
    output logic             result_valid,
    output logic      [2:0]  result_source,
    output logic      [15:0] result_data
);
    param_bank_pkg::bank_state_t state;       // registered state
    param_bank_pkg::bank_state_t next_state;  // next value
    logic                        low_bits;    // alignment of this conv
    logic                        chan_on;     // channel of this conv on

    // pick enable and alignment for the arriving conversion
    always_comb begin
        low_bits = 1'b0;
        chan_on  = 1'b0;
        case (param_bank_pkg::conv_source_t'(conv_source))
            param_bank_pkg::SRC_PROX_ONE: begin
                chan_on  = state.channel_enable_list[`PB_BIT_PROX_ONE];
                low_bits = prox_one_low_bits;
            end
            param_bank_pkg::SRC_PROX_TWO: begin
                chan_on  = state.channel_enable_list[`PB_BIT_PROX_TWO];
                low_bits = prox_two_low_bits;
            end
            param_bank_pkg::SRC_PROX_THREE: begin
                chan_on  = state.channel_enable_list[`PB_BIT_PROX_THREE];
                low_bits = prox_three_low_bits;
            end
            param_bank_pkg::SRC_AMB_VIS: begin
                chan_on  = state.channel_enable_list[`PB_BIT_AMB_VIS];
                low_bits = ambient_bit5_low_bits;
            end
            param_bank_pkg::SRC_AMB_IR: begin
                chan_on  = state.channel_enable_list[`PB_BIT_AMB_IR];
                low_bits = ambient_bit4_low_bits;
            end
            param_bank_pkg::SRC_AUX: begin
                chan_on  = state.channel_enable_list[`PB_BIT_AUX];
                low_bits = 1'b0;  // auxiliary keeps the upper bits
            end
            default: begin
                chan_on  = 1'b0;  // unknown source is dropped
                low_bits = 1'b0;
            end
        endcase
    end

    // next state: writes, reads, address switch and result alignment
    always_comb begin
        next_state              = state;
        next_state.rdata_valid  = 1'b0;
        next_state.result_valid = 1'b0;
        // writes keep only implemented bits
        if (parameter_write_cmd) begin
            case (param_offset)
                `PB_OFS_BUS_ADDR:
                    next_state.bus_address_param = param_wdata;
                `PB_OFS_CHAN_LIST:
                    next_state.channel_enable_list =
                        param_wdata & `PB_MASK_CHAN_LIST;
                `PB_OFS_LED12:
                    next_state.prox_led_select_one_two =
                        param_wdata & `PB_MASK_LED12;
                `PB_OFS_LED3:
                    next_state.prox_led_select_three =
                        param_wdata & `PB_MASK_LED3;
                `PB_OFS_PROX_ALIGN:
                    next_state.prox_result_alignment =
                        param_wdata & `PB_MASK_PROX_AL;
                `PB_OFS_AMB_ALIGN:
                    next_state.ambient_result_alignment =
                        param_wdata & `PB_MASK_AMB_AL;
                `PB_OFS_HISTORY:
                    next_state.ambient_history_setting = param_wdata;
                `PB_OFS_OFFSET:
                    next_state.converter_offset_setting = param_wdata;
                `PB_OFS_REC_TIME:
                    next_state.emitter_recovery_time = param_wdata;
                `PB_OFS_IR_COUNT:
                    next_state.ambient_ir_recovery_count =
                        param_wdata & `PB_MASK_IR_COUNT;
                `PB_OFS_IR_GAIN:
                    next_state.ambient_ir_gain =
                        param_wdata & `PB_MASK_IR_GAIN;
                `PB_OFS_SELECT_A:
                    next_state.ambient_select_a_ctl =
                        param_wdata & `PB_MASK_SELECT_A;
                default: ;  // reserved and unmapped: ignored
            endcase
        end
        // reads return the value held before a same-cycle write
        if (parameter_read_cmd) begin
            next_state.rdata_valid = 1'b1;
            case (param_offset)
                `PB_OFS_BUS_ADDR:   next_state.rdata = state.bus_address_param;
                `PB_OFS_CHAN_LIST:
                    next_state.rdata = state.channel_enable_list;
                `PB_OFS_LED12:
                    next_state.rdata = state.prox_led_select_one_two;
                `PB_OFS_LED3:
                    next_state.rdata = state.prox_led_select_three;
                `PB_OFS_PROX_ALIGN:
                    next_state.rdata = state.prox_result_alignment;
                `PB_OFS_AMB_ALIGN:
                    next_state.rdata = state.ambient_result_alignment;
                `PB_OFS_HISTORY:
                    next_state.rdata = state.ambient_history_setting;
                `PB_OFS_OFFSET:
                    next_state.rdata = state.converter_offset_setting;
                `PB_OFS_REC_TIME:
                    next_state.rdata = state.emitter_recovery_time;
                `PB_OFS_IR_COUNT:
                    next_state.rdata = state.ambient_ir_recovery_count;
                `PB_OFS_IR_GAIN:    next_state.rdata = state.ambient_ir_gain;
                `PB_OFS_SELECT_A:
                    next_state.rdata = state.ambient_select_a_ctl;
                default:            next_state.rdata = `PB_RST_ZERO;
            endcase
        end
        // stored address takes over only on the command
        if (apply_bus_address_cmd) begin
            next_state.active_bus_address = state.bus_address_param;
        end
        // enabled channels yield an aligned 16-bit result
        if (conv_valid && chan_on) begin
            next_state.result_valid  = 1'b1;
            next_state.result_source =
                param_bank_pkg::conv_source_t'(conv_source);
            next_state.result_data   =
                low_bits ? conv_data[15:0] : conv_data[16:1];
        end
    end

    // register the whole state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{
                bus_address_param:         `PB_RST_ZERO,
                active_bus_address:        RESET_BUS_ADDRESS,
                channel_enable_list:       `PB_RST_ZERO,
                prox_led_select_one_two:   `PB_RST_LED12,
                prox_led_select_three:     `PB_RST_LED3,
                prox_result_alignment:     `PB_RST_ZERO,
                ambient_result_alignment:  `PB_RST_ZERO,
                ambient_history_setting:   `PB_RST_ZERO,
                converter_offset_setting:  `PB_RST_ZERO,
                emitter_recovery_time:     `PB_RST_ZERO,
                ambient_ir_recovery_count: `PB_RST_ZERO,
                ambient_ir_gain:           `PB_RST_ZERO,
                ambient_select_a_ctl:      `PB_RST_ZERO,
                rdata:                     `PB_RST_ZERO,
                rdata_valid:               1'b0,
                result_data:               16'h0000,
                result_valid:              1'b0,
                result_source:             param_bank_pkg::SRC_PROX_ONE
            };
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state flops
    assign param_rdata       = state.rdata;
    assign param_rdata_valid = state.rdata_valid;
    assign active_bus_address = state.active_bus_address;
    assign prox_one_on   = state.channel_enable_list[`PB_BIT_PROX_ONE];
    assign prox_two_on   = state.channel_enable_list[`PB_BIT_PROX_TWO];
    assign prox_three_on = state.channel_enable_list[`PB_BIT_PROX_THREE];
    assign ambient_visible_channel_on =
        state.channel_enable_list[`PB_BIT_AMB_VIS];
    assign ambient_ir_channel_on = state.channel_enable_list[`PB_BIT_AMB_IR];
    assign aux_channel_on        = state.channel_enable_list[`PB_BIT_AUX];
    assign prox_one_driver_mask   = state.prox_led_select_one_two[2:0];
    assign prox_two_driver_mask   = state.prox_led_select_one_two[6:4];
    assign prox_three_driver_mask = state.prox_led_select_three[2:0];
    assign prox_one_low_bits =
        state.prox_result_alignment[`PB_BIT_PROX_ONE_AL];
    assign prox_two_low_bits =
        state.prox_result_alignment[`PB_BIT_PROX_TWO_AL];
    assign prox_three_low_bits =
        state.prox_result_alignment[`PB_BIT_PROX_THREE_AL];
    assign ambient_bit5_low_bits =
        state.ambient_result_alignment[`PB_BIT_AMB_B5_AL];
    assign ambient_bit4_low_bits =
        state.ambient_result_alignment[`PB_BIT_AMB_B4_AL];
    assign result_valid  = state.result_valid;
    assign result_source = state.result_source;
    assign result_data   = state.result_data;

    // checks on the bank
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_addr_hold;
        !apply_bus_address_cmd |=> $stable(active_bus_address);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("bus address moved without command");

    property p_addr_switch;
        apply_bus_address_cmd |=>
            active_bus_address == $past(state.bus_address_param);
    endproperty
    a_addr_switch: assert property (p_addr_switch)
        else $error("bus address not applied");

    property p_aux_gate;
        conv_valid && conv_source == param_bank_pkg::SRC_AUX |=>
            result_valid == $past(state.channel_enable_list[6]);
    endproperty
    a_aux_gate: assert property (p_aux_gate)
        else $error("auxiliary result gating wrong");

    property p_ir_gate;
        conv_valid && conv_source == param_bank_pkg::SRC_AMB_IR |=>
            result_valid == $past(state.channel_enable_list[5]);
    endproperty
    a_ir_gate: assert property (p_ir_gate)
        else $error("ambient ir result gating wrong");

    property p_vis_gate;
        conv_valid && conv_source == param_bank_pkg::SRC_AMB_VIS |=>
            result_valid == $past(state.channel_enable_list[4]);
    endproperty
    a_vis_gate: assert property (p_vis_gate)
        else $error("ambient visible result gating wrong");

    property p_prox_gate;
        conv_valid && conv_source == param_bank_pkg::SRC_PROX_THREE |=>
            result_valid == $past(state.channel_enable_list[2]);
    endproperty
    a_prox_gate: assert property (p_prox_gate)
        else $error("proximity three result gating wrong");

    property p_led12_write;
        parameter_write_cmd && param_offset == 5'h02 |=>
            prox_one_driver_mask == $past(param_wdata[2:0]) &&
            prox_two_driver_mask == $past(param_wdata[6:4]);
    endproperty
    a_led12_write: assert property (p_led12_write)
        else $error("driver masks one or two not stored");

    property p_led3_write;
        parameter_write_cmd && param_offset == 5'h03 |=>
            prox_three_driver_mask == $past(param_wdata[2:0]);
    endproperty
    a_led3_write: assert property (p_led3_write)
        else $error("driver mask three not stored");

    property p_prox_align;
        conv_valid && chan_on &&
        conv_source == param_bank_pkg::SRC_PROX_ONE |=>
            result_data == ($past(prox_one_low_bits) ?
                $past(conv_data[15:0]) : $past(conv_data[16:1]));
    endproperty
    a_prox_align: assert property (p_prox_align)
        else $error("proximity alignment wrong");

    property p_vis_align;
        conv_valid && chan_on &&
        conv_source == param_bank_pkg::SRC_AMB_VIS |=>
            result_data == ($past(ambient_bit5_low_bits) ?
                $past(conv_data[15:0]) : $past(conv_data[16:1]));
    endproperty
    a_vis_align: assert property (p_vis_align)
        else $error("visible alignment wrong");

    property p_rsvd_read;
        parameter_read_cmd && param_offset == 5'h1B |=>
            param_rdata_valid && param_rdata == 8'h00;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved parameter not zero");

    c_write_read: cover property (parameter_write_cmd ##1
        parameter_read_cmd ##1 param_rdata_valid);
    c_addr_apply: cover property (apply_bus_address_cmd ##1
        active_bus_address != $past(active_bus_address));
    c_low_result: cover property (result_valid && prox_one_low_bits);
endmodule
`default_nettype wire

// *** bench/host_param_model.sv ***
// host-side model that issues parameter commands to the bank
`timescale 1ns/100ps
`default_nettype none
module host_param_model (
    // clock
    input  wire logic       sys_clk,
    // command port towards the bank
    output logic            parameter_write_cmd,
    output logic            parameter_read_cmd,
    output logic      [4:0] param_offset,
    output logic      [7:0] param_wdata,
    output logic            apply_bus_address_cmd,
    // read answer from the bank
    input  wire logic [7:0] param_rdata,
    input  wire logic       param_rdata_valid
);
    // idle: no request; qualifiers carry a changing pattern
    initial begin
        parameter_write_cmd   = 1'b0;
        parameter_read_cmd    = 1'b0;
        apply_bus_address_cmd = 1'b0;
        param_offset          = 5'h15;
        param_wdata           = 8'hA5;
    end

    // parameter write; the bank is reached only by these commands
    // callers never write the reserved 0x1B parameter
    // three-driver variant fitted, so every mask bit is legal
    task automatic write_param(input logic [4:0] ofs,
                               input logic [7:0] val);
        @(posedge sys_clk);
        #1;
        parameter_write_cmd = 1'b1;
        param_offset        = ofs;
        param_wdata         = val;
        @(posedge sys_clk);
        #1;
        parameter_write_cmd = 1'b0;
        param_offset        = ~ofs; // released lines lose their value
        param_wdata         = ~val;
    endtask

    // parameter read; answer sampled in the cycle after the request
    task automatic read_param(input  logic [4:0] ofs,
                              output logic [7:0] val,
                              output logic       ok);
        @(posedge sys_clk);
        #1;
        parameter_read_cmd = 1'b1;
        param_offset       = ofs;
        @(posedge sys_clk);
        #1;
        parameter_read_cmd = 1'b0;
        param_offset       = ~ofs;
        ok                 = param_rdata_valid;
        val                = param_rdata;
    endtask

    // apply the stored bus address
    task automatic apply_addr();
        @(posedge sys_clk);
        #1;
        apply_bus_address_cmd = 1'b1;
        @(posedge sys_clk);
        #1;
        apply_bus_address_cmd = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** bench/sensor_channel_parameter_bank_tb.sv ***
// self-checking bench for the sensor channel parameter bank
`timescale 1ns/100ps
`default_nettype none
module sensor_channel_parameter_bank_tb;
    // clock, reset and command nets
    logic        sys_clk, rst_n;
    logic        parameter_write_cmd, parameter_read_cmd;
    logic [4:0]  param_offset;
    logic [7:0]  param_wdata, param_rdata, active_bus_address;
    logic        param_rdata_valid, apply_bus_address_cmd;
    // decoded outputs
    logic        prox_one_on, prox_two_on, prox_three_on;
    logic        ambient_visible_channel_on, ambient_ir_channel_on;
    logic        aux_channel_on;
    logic [2:0]  prox_one_driver_mask, prox_two_driver_mask;
    logic [2:0]  prox_three_driver_mask;
    logic        prox_one_low_bits, prox_two_low_bits, prox_three_low_bits;
    logic        ambient_bit5_low_bits, ambient_bit4_low_bits;
    // conversion port
    logic        conv_valid, result_valid;
    logic [2:0]  conv_source, result_source;
    logic [16:0] conv_data;
    logic [15:0] result_data;
    // bookkeeping
    int          fail_count, checks_done, cycles;
    // offsets written with all ones, and the expected readback
    logic [4:0]  ofs_tab [14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06,
        5'h19, 5'h1A, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h04, 5'h10};
    logic [7:0]  exp_tab [14] = '{8'hFF, 8'h77, 8'h77, 8'h07, 8'h70, 8'h30,
        8'hFF, 8'hFF, 8'hFF, 8'h70, 8'h07, 8'h20, 8'h00, 8'h00};

    sensor_channel_parameter_bank DUT (.*);
    host_param_model host (.*);

    // clock at 40 MHz
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            end_of_test();
        end
    end

    // byte compare
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // word compare
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read one parameter and judge valid and data
    task automatic rd_check(input logic [4:0] ofs, input logic [7:0] exp);
        logic [7:0] v;
        logic       ok;
        host.read_param(ofs, v, ok);
        check8({7'h00, ok}, 8'h01);
        check8(v, exp);
    endtask

    // packed view of the three driver masks
    function automatic logic [15:0] masks();
        return {5'h00, prox_three_driver_mask, 1'b0, prox_two_driver_mask,
                1'b0, prox_one_driver_mask};
    endfunction

    // send one conversion and judge the result
    task automatic conv(input logic [2:0] src, input logic [16:0] d,
                        input logic ev, input logic [15:0] ed);
        @(posedge sys_clk);
        #1;
        conv_valid  = 1'b1;
        conv_source = src;
        conv_data   = d;
        @(posedge sys_clk);
        #1;
        conv_valid  = 1'b0;
        conv_source = ~src;
        conv_data   = ~d;
        check8({7'h00, result_valid}, {7'h00, ev});
        if (ev) begin
            check16(result_data, ed);
            check8({5'h00, result_source}, {5'h00, src});
        end
    endtask

    // reset values of the bank and its outputs
    task automatic t_reset();
        rd_check(5'h00, 8'h00);
        rd_check(5'h01, 8'h00);
        rd_check(5'h02, 8'h21);
        rd_check(5'h03, 8'h04);
        rd_check(5'h05, 8'h00);
        rd_check(5'h06, 8'h00);
        rd_check(5'h1B, 8'h00);
        check16(masks(), 16'h0421);
        check8(active_bus_address, 8'h00);
    endtask

    // all-ones writes: reserved bits and places stay zero
    task automatic t_write_masks();
        for (int i = 0; i < 14; i++) begin
            host.write_param(ofs_tab[i], 8'hFF);
            rd_check(ofs_tab[i], exp_tab[i]);
        end
        check16(masks(), 16'h0777);
    endtask

    // each list bit drives only its own channel enable
    task automatic t_channels();
        int bits [6] = '{0, 1, 2, 4, 5, 6};
        for (int i = 0; i < 6; i++) begin
            host.write_param(5'h01, 8'h01 << bits[i]);
            check8({1'b0, aux_channel_on, ambient_ir_channel_on,
                    ambient_visible_channel_on, 1'b0, prox_three_on,
                    prox_two_on, prox_one_on},
                   8'h01 << bits[i]);
        end
    endtask

    // driver selections, combinations and no drive
    task automatic t_drivers();
        host.write_param(5'h02, 8'h53);
        host.write_param(5'h03, 8'h06);
        check16(masks(), 16'h0653);
        host.write_param(5'h02, 8'h00);
        check16(masks(), 16'h0600);
    endtask

    // stored address takes effect only on the apply command
    task automatic t_address();
        host.write_param(5'h00, 8'h3C);
        check8(active_bus_address, 8'h00);
        host.apply_addr();
        check8(active_bus_address, 8'h3C);
        host.write_param(5'h00, 8'hA5);
        check8(active_bus_address, 8'h3C);
    endtask

    // one alignment bit at a time; only its measurement takes low bits
    task automatic t_align();
        logic [16:0] d;
        logic [7:0]  pa, aa;
        d = 17'h1B5A7;
        host.write_param(5'h01, 8'h77);
        for (int k = 0; k < 5; k++) begin
            pa = (k < 3) ? (8'h10 << k) : 8'h00;
            aa = (k == 3) ? 8'h20 : ((k == 4) ? 8'h10 : 8'h00);
            host.write_param(5'h05, pa);
            host.write_param(5'h06, aa);
            check8({3'h0, prox_three_low_bits, prox_two_low_bits,
                    prox_one_low_bits, ambient_bit5_low_bits,
                    ambient_bit4_low_bits},
                   {3'h0, pa[6:4], aa[5:4]});
            for (int s = 0; s < 6; s++) begin
                conv(3'(s), d, 1'b1,
                     (s == k) ? d[15:0] : d[16:1]);
            end
        end
        host.write_param(5'h01, 8'h76);
        conv(3'h0, d, 1'b0, 16'h0000);
        conv(3'h6, d, 1'b0, 16'h0000);
        conv(3'h1, d, 1'b1, d[16:1]);
    endtask

    // verdict and end of run
    task automatic end_of_test();
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        fail_count  = 0;
        checks_done = 0;
        cycles      = 0;
        rst_n       = 1'b0;
        conv_valid  = 1'b0;
        conv_source = 3'h0;
        conv_data   = 17'h00000;
        repeat (5) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_write_masks();
        t_channels();
        t_drivers();
        t_address();
        t_align();
        end_of_test();
    end
endmodule
`default_nettype wire
